// ---- core/arf_formatter.sv ----
// Contract
// - Repeat count one: each 12-bit unsigned result refreshes the pair per conversion.
// - Repeat count one: justify bit clear puts code in bits 11..0, set puts it in 15..4; sums are always right-justified.
// - Result bits not holding the value read as zero in every setting.
// - Repeat count above one: sum series, update pair once after last conversion.
// - Repeat-count field selects 4, 8 or 16 samples, summed as unsigned.
// - Raw codes are added unscaled; full-scale sums 0x3FFC, 0x7FF8, 0xFFF0.
`timescale 1ns/1ns
module arf_formatter
  import arf_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic [ARF_CODE_W-1:0] SAMPLE_CODE,
  input wire logic SAMPLE_DONE,
  input wire logic LEFT_JUSTIFY_SELECT,
  input wire logic [1:0] REPEAT_COUNT_FIELD,
  output logic [ARF_BYTE_W-1:0] RESULT_HIGH_BYTE,
  output logic [ARF_BYTE_W-1:0] RESULT_LOW_BYTE,
  output logic RESULT_UPDATED
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [ARF_CNT_W-1:0] last_index(input logic [1:0] rpt);
    case (rpt)
      ARF_RPT_4: last_index = ARF_LAST_4;
      ARF_RPT_8: last_index = ARF_LAST_8;
      ARF_RPT_16: last_index = ARF_LAST_16;
      default: last_index = ARF_LAST_1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  arf_state_t state_r, state_nxt;
  logic [ARF_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [ARF_RES_W-1:0] acc_r, acc_nxt;
  logic [ARF_CNT_W-1:0] last_r, last_nxt;
  logic [ARF_RES_W-1:0] res_r, res_nxt;
  logic upd_r, upd_nxt;
  logic [ARF_RES_W-1:0] sum_now;
  logic [ARF_RES_W-1:0] formatted;
  logic single_now;

  // Sixteen 12-bit codes fit exactly in 16 bits, so the sum never overflows.
  assign sum_now = acc_r + {{(ARF_RES_W-ARF_CODE_W){1'b0}}, SAMPLE_CODE};
  assign single_now = (last_r == ARF_LAST_1);

  arf_justify u_justify (
    .sum_in(sum_now),
    .left_justify_select(LEFT_JUSTIFY_SELECT),
    .single_mode(single_now),
    .result_out(formatted)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The repeat count is latched at the first sample of a series so that a change in
  // mid-series cannot shorten or stretch the series in progress.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    last_nxt = last_r;
    res_nxt = res_r;
    upd_nxt = 1'b0;
    case (state_r)
      ARF_IDLE: begin
        last_nxt = last_index(REPEAT_COUNT_FIELD);
        if (SAMPLE_DONE) begin
          if (last_index(REPEAT_COUNT_FIELD) == ARF_LAST_1) begin
            res_nxt = LEFT_JUSTIFY_SELECT ?
              {SAMPLE_CODE, {ARF_LJ_SHIFT{1'b0}}} :
              {{(ARF_RES_W-ARF_CODE_W){1'b0}}, SAMPLE_CODE};
            upd_nxt = 1'b1;
          end else begin
            acc_nxt = {{(ARF_RES_W-ARF_CODE_W){1'b0}}, SAMPLE_CODE};
            cnt_nxt = 4'h1;
            state_nxt = ARF_ACCUM;
          end
        end
      end
      ARF_ACCUM: begin
        if (SAMPLE_DONE) begin
          if (cnt_r == last_r) begin
            res_nxt = formatted;
            upd_nxt = 1'b1;
            acc_nxt = ARF_RES_RST;
            cnt_nxt = 4'h0;
            state_nxt = ARF_IDLE;
          end else begin
            acc_nxt = sum_now;
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      default: begin
        state_nxt = ARF_IDLE;
        cnt_nxt = 4'h0;
        acc_nxt = ARF_RES_RST;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_r <= ARF_IDLE;
      cnt_r <= 4'h0;
      acc_r <= ARF_RES_RST;
      last_r <= ARF_LAST_1;
      res_r <= ARF_RES_RST;
      upd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      last_r <= last_nxt;
      res_r <= res_nxt;
      upd_r <= upd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both bytes come from one 16-bit register, so they always belong to one result.
  assign RESULT_HIGH_BYTE = res_r[ARF_RES_W-1:ARF_BYTE_W];
  assign RESULT_LOW_BYTE = res_r[ARF_BYTE_W-1:0];
  assign RESULT_UPDATED = upd_r;

endmodule

// ---- core/arf_pkg.sv ----
package arf_pkg;

  localparam int ARF_CODE_W = 12;
  localparam int ARF_RES_W = 16;
  localparam int ARF_BYTE_W = 8;
  localparam int ARF_CNT_W = 4;
  localparam int ARF_LJ_SHIFT = 4;

  // Encoding of the repeat-count field.
  localparam logic [1:0] ARF_RPT_1 = 2'h0;
  localparam logic [1:0] ARF_RPT_4 = 2'h1;
  localparam logic [1:0] ARF_RPT_8 = 2'h2;
  localparam logic [1:0] ARF_RPT_16 = 2'h3;

  // Last sample index of a series for each repeat count.
  localparam logic [3:0] ARF_LAST_1 = 4'h0;
  localparam logic [3:0] ARF_LAST_4 = 4'h3;
  localparam logic [3:0] ARF_LAST_8 = 4'h7;
  localparam logic [3:0] ARF_LAST_16 = 4'hf;

  localparam logic [15:0] ARF_RES_RST = 16'h0000;

  typedef enum logic [0:0] {
    ARF_IDLE,
    ARF_ACCUM
  } arf_state_t;

endpackage

// ---- core/arf_justify.sv ----
`timescale 1ns/1ns
module arf_justify
  import arf_pkg::*;
(
  input wire logic [ARF_RES_W-1:0] sum_in,
  input wire logic left_justify_select,
  input wire logic single_mode,
  output logic [ARF_RES_W-1:0] result_out
);

  // Left justification applies to single samples only; sums are always right-justified.
  always_comb begin
    if (single_mode && left_justify_select) begin
      result_out = {sum_in[ARF_CODE_W-1:0], {ARF_LJ_SHIFT{1'b0}}};
    end else begin
      result_out = sum_in;
    end
  end

endmodule

// ---- sim/arf_conv_model.sv ----
`timescale 1ns/1ns
module arf_conv_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [11:0] code,
  output logic [11:0] sample_code = 12'h000,
  output logic sample_done = 1'b0
);
  // Off the done pulse the code flips every cycle, so a stale code never passes for a valid one.
  always @(posedge clk) begin
    sample_done <= go;
    sample_code <= go ? code : ~sample_code;
  end
endmodule

// ---- sim/arf_formatter_properties.sv ----
`timescale 1ns/1ns
module arf_formatter_properties
  import arf_pkg::*;
(
  input wire logic CORE_CLK, SRST, SAMPLE_DONE, LEFT_JUSTIFY_SELECT, RESULT_UPDATED,
  input wire logic [ARF_CODE_W-1:0] SAMPLE_CODE,
  input wire logic [1:0] REPEAT_COUNT_FIELD,
  input wire logic [ARF_BYTE_W-1:0] RESULT_HIGH_BYTE, RESULT_LOW_BYTE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  wire [15:0] res = {RESULT_HIGH_BYTE, RESULT_LOW_BYTE};
  wire one = SAMPLE_DONE && REPEAT_COUNT_FIELD == ARF_RPT_1;
  property p_one; one && $stable(REPEAT_COUNT_FIELD) |=> RESULT_UPDATED; endproperty
  a_one: assert property (p_one) else $error("single result missing");
  property p_rj; one && !LEFT_JUSTIFY_SELECT |=> res == {4'h0, $past(SAMPLE_CODE)}; endproperty
  a_rj: assert property (p_rj) else $error("right result wrong");
  property p_lj; one && LEFT_JUSTIFY_SELECT |=> res == {$past(SAMPLE_CODE), 4'h0}; endproperty
  a_lj: assert property (p_lj) else $error("left result wrong");
  property p_src; RESULT_UPDATED |-> $past(SAMPLE_DONE); endproperty
  a_src: assert property (p_src) else $error("update without sample");
  // A sum takes at least four samples, so the three cycles before its update carry no other update.
  // A single result may follow a sum at once, so nothing is claimed about the cycles after it.
  property p_gap;
    RESULT_UPDATED && $past(REPEAT_COUNT_FIELD) != ARF_RPT_1 |->
      !$past(RESULT_UPDATED, 1) && !$past(RESULT_UPDATED, 2) && !$past(RESULT_UPDATED, 3);
  endproperty
  a_gap: assert property (p_gap) else $error("sum updated early");
  property p_sum4; RESULT_UPDATED && $past(REPEAT_COUNT_FIELD) == ARF_RPT_4 |-> res <= 16'h3ffc; endproperty
  a_sum4: assert property (p_sum4) else $error("sum of four too large");
  property p_pair; !$stable(res) |-> RESULT_UPDATED; endproperty
  a_pair: assert property (p_pair) else $error("bytes moved alone");
endmodule
bind arf_formatter arf_formatter_properties u_props (.*);

// ---- sim/tb_arf_formatter.sv ----
`timescale 1ns/1ns
module tb_arf_formatter
  import arf_pkg::*;
;
  logic CORE_CLK = 1'b0, SRST = 1'b1, LEFT_JUSTIFY_SELECT = 1'b0, go = 1'b0, SAMPLE_DONE, RESULT_UPDATED;
  logic [1:0] REPEAT_COUNT_FIELD = 2'h0;
  logic [11:0] code = 12'h000, SAMPLE_CODE;
  logic [7:0] RESULT_HIGH_BYTE, RESULT_LOW_BYTE;
  int fails = 0, total_checks = 0;
  always #50 CORE_CLK = ~CORE_CLK;
  arf_conv_model conv (.clk(CORE_CLK), .go(go), .code(code), .sample_code(SAMPLE_CODE), .sample_done(SAMPLE_DONE));
  arf_formatter dut (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST),
    .SAMPLE_CODE(SAMPLE_CODE),
    .SAMPLE_DONE(SAMPLE_DONE),
    .LEFT_JUSTIFY_SELECT(LEFT_JUSTIFY_SELECT),
    .REPEAT_COUNT_FIELD(REPEAT_COUNT_FIELD),
    .RESULT_HIGH_BYTE(RESULT_HIGH_BYTE),
    .RESULT_LOW_BYTE(RESULT_LOW_BYTE),
    .RESULT_UPDATED(RESULT_UPDATED)
  );
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic series(input logic [1:0] r, input logic l, input logic [11:0] c, input int n, input logic [15:0] e);
    REPEAT_COUNT_FIELD = r;
    LEFT_JUSTIFY_SELECT = l;
    code = c;
    repeat (2) @(posedge CORE_CLK);
    #1 go = 1'b1;
    repeat (n) begin
      @(posedge CORE_CLK);
      #1 total_checks++;
      if (RESULT_UPDATED !== 1'b0) begin
        fails++;
        $display("Error early update expected 0 seen %b", RESULT_UPDATED);
      end
    end
    go = 1'b0;
    @(posedge CORE_CLK);
    #1 total_checks++;
    if ({RESULT_HIGH_BYTE, RESULT_LOW_BYTE, RESULT_UPDATED} !== {e, 1'b1}) begin
      fails++;
      $display("Error result expected %h seen %h", e, {RESULT_HIGH_BYTE, RESULT_LOW_BYTE});
    end
  endtask
  task automatic t_single();
    series(ARF_RPT_1, 1'b0, 12'hfff, 1, 16'h0fff);
    series(ARF_RPT_1, 1'b1, 12'hfff, 1, 16'hfff0);
    series(ARF_RPT_1, 1'b1, 12'h7ff, 1, 16'h7ff0);
    series(ARF_RPT_1, 1'b0, 12'h800, 1, 16'h0800);
  endtask
  // Justify stays clear whenever samples are summed.
  task automatic t_accum();
    series(ARF_RPT_4, 1'b0, 12'hfff, 4, 16'h3ffc);
    series(ARF_RPT_8, 1'b0, 12'h7ff, 8, 16'h3ff8);
    series(ARF_RPT_16, 1'b0, 12'hfff, 16, 16'hfff0);
  endtask
  initial begin
    #200000 fails++;
    results();
  end
  initial begin
    repeat (2) @(posedge CORE_CLK);
    #1 SRST = 1'b0;
    t_single();
    t_accum();
    results();
  end
endmodule
